// ===== sbs_ctl.sv
// Burst SRAM control: address strobes, selects, burst counter, write lanes
`timescale 1ns/1ns
`default_nettype none
module sbs_ctl (
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_i,
	input  wire logic [sbs_pkg::ADDR_W-1:0]  addr_i,
	input  wire logic [sbs_pkg::DATA_W-1:0]  data_i,
	output logic      [sbs_pkg::DATA_W-1:0]  data_o,
	output logic                             data_oe_o,
	input  wire logic                        chip_select_n_i,
	input  wire logic                        secondary_select_i,
	input  wire logic                        third_select_n_i,
	input  wire logic                        cpu_addr_strobe_n_i,
	input  wire logic                        ctl_addr_strobe_n_i,
	input  wire logic                        burst_step_n_i,
	input  wire logic                        whole_word_write_n_i,
	input  wire logic                        byte_write_gate_n_i,
	input  wire logic                        lane_low_write_n_i,
	input  wire logic                        lane_high_write_n_i,
	input  wire logic                        out_enable_n_i,
	input  wire logic                        sleep_req_i,
	input  wire logic                        burst_order_i,
	output logic                             mem_rd_en_o,
	output logic      [sbs_pkg::ADDR_W-1:0]  mem_rd_addr_o,
	input  wire logic [sbs_pkg::DATA_W-1:0]  mem_rd_data_i,
	output logic                             mem_wr_valid_o,
	output logic      [sbs_pkg::ADDR_W-1:0]  mem_wr_addr_o,
	output logic      [sbs_pkg::DATA_W-1:0]  mem_wr_data_o,
	output logic      [sbs_pkg::LANES-1:0]   mem_wr_lanes_o,
	input  wire logic                        mem_wr_ready_i,
	output logic                             wr_ready_o,
	output logic                             sleep_o
);
	typedef struct packed {
		logic [1:0]                 oe_sync;
		logic [1:0]                 slp_sync;
		logic [1:0]                 ord_sync;
		sbs_pkg::sbs_mode_t         mode;
		logic [sbs_pkg::ADDR_W-1:0] base;
		logic [1:0]                 cnt;
		logic                       rd_en;
		logic [sbs_pkg::ADDR_W-1:0] rd_addr;
		logic [sbs_pkg::DATA_W-1:0] dq;
		logic                       dq_oe;
	} sbs_ctl_state_t;

	sbs_ctl_state_t             s_q;
	sbs_ctl_state_t             s_d;
	logic                       sel_ok;
	logic                       cpu_new;
	logic                       ctl_new;
	logic                       new_any;
	logic                       sleeping;
	logic                       interleave;
	logic                       step;
	logic                       cont;
	logic [1:0]                 lanes_c;
	logic                       wr_c;
	logic [1:0]                 cnt_nx;
	logic [1:0]                 lo_nx;
	logic [sbs_pkg::ADDR_W-1:0] cont_addr;
	logic                       acc_wr;
	sbs_pkg::sbs_wr_word_t      wr_word;
	sbs_pkg::sbs_wr_word_t      drain_word;

	sbs_stream_if #(.W(sbs_pkg::WR_W)) wr_in ();
	sbs_stream_if #(.W(sbs_pkg::WR_W)) wr_out ();

	// Writes land in the buffer so a slow array never stalls the pin timing
	sbs_fifo #(
		.W     (sbs_pkg::WR_W),
		.DEPTH (sbs_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk_i (ref_clk_i),
		.rst_i (rst_i),
		.in_s  (wr_in),
		.out_s (wr_out)
	);

	// Only the second stage of each synchroniser is read
	assign sleeping   = s_q.slp_sync[1];
	assign interleave = s_q.ord_sync[1];

	assign sel_ok  = !chip_select_n_i && secondary_select_i && !third_select_n_i;
	assign cpu_new = !cpu_addr_strobe_n_i && !chip_select_n_i;
	assign ctl_new = !ctl_addr_strobe_n_i && !cpu_new;
	assign new_any = cpu_new || ctl_new;
	assign step    = !burst_step_n_i;
	assign cont    = !sleeping && !new_any
		&& (s_q.mode == sbs_pkg::SBS_RD || s_q.mode == sbs_pkg::SBS_WR);

	always_comb begin
		if (!whole_word_write_n_i) begin
			lanes_c = sbs_pkg::LANES_ALL;
		end else if (!byte_write_gate_n_i) begin
			lanes_c = {!lane_high_write_n_i, !lane_low_write_n_i};
		end else begin
			lanes_c = sbs_pkg::LANES_NONE;
		end
	end
	assign wr_c = (lanes_c != sbs_pkg::LANES_NONE);

	assign cnt_nx = step ? s_q.cnt + sbs_pkg::CNT_STEP : s_q.cnt;
	// Linear wraps naturally in two bits
	assign lo_nx = interleave ? (s_q.base[1:0] ^ cnt_nx)
		: (s_q.base[1:0] + cnt_nx);
	assign cont_addr = {s_q.base[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_LSB], lo_nx};

	always_comb begin
		s_d          = s_q;
		acc_wr       = 1'b0;
		wr_word.addr = cont_addr;
		wr_word.data = data_i;
		wr_word.lanes = lanes_c;
		s_d.oe_sync  = {s_q.oe_sync[0], out_enable_n_i};
		s_d.slp_sync = {s_q.slp_sync[0], sleep_req_i};
		s_d.ord_sync = {s_q.ord_sync[0], burst_order_i};
		s_d.rd_en    = 1'b0;
		if (sleeping) begin
			s_d.mode = sbs_pkg::SBS_SLEEP;
		end else if (new_any) begin
			s_d.base = addr_i;
			s_d.cnt  = sbs_pkg::CNT_RST;
			wr_word.addr = addr_i;
			if (!sel_ok) begin
				s_d.mode = sbs_pkg::SBS_DESEL;
			end else if (cpu_new || !wr_c) begin
				s_d.mode    = sbs_pkg::SBS_RD;
				s_d.rd_en   = 1'b1;
				s_d.rd_addr = addr_i;
			end else begin
				s_d.mode = sbs_pkg::SBS_WR;
				acc_wr   = 1'b1;
			end
		end else begin
			unique case (s_q.mode)
				sbs_pkg::SBS_DESEL,
				sbs_pkg::SBS_SLEEP: begin
					s_d.mode = sbs_pkg::SBS_DESEL;
				end
				sbs_pkg::SBS_RD,
				sbs_pkg::SBS_WR: begin
					s_d.cnt = cnt_nx;
					// Wait cycle after a processor strobe may turn into a write
					if (wr_c) begin
						s_d.mode = sbs_pkg::SBS_WR;
						acc_wr   = 1'b1;
					end else begin
						s_d.mode    = sbs_pkg::SBS_RD;
						s_d.rd_en   = 1'b1;
						s_d.rd_addr = cont_addr;
					end
				end
			endcase
		end
		if (s_q.rd_en) begin
			s_d.dq = s_q.rd_en ? mem_rd_data_i : s_q.dq;
		end
		// Enable follows the pin through its synchroniser and this register, so it lags by three edges
		s_d.dq_oe = !s_q.oe_sync[1] && !sleeping && s_q.rd_en;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// A write met by a full buffer is lost; wr_ready_o lets the master hold off
	assign wr_in.valid = acc_wr;
	assign wr_in.data  = wr_word;
	assign wr_ready_o  = wr_in.ready;

	assign drain_word     = wr_out.data;
	assign wr_out.ready   = mem_wr_ready_i;
	assign mem_wr_valid_o = wr_out.valid;
	assign mem_wr_addr_o  = drain_word.addr;
	assign mem_wr_data_o  = drain_word.data;
	assign mem_wr_lanes_o = drain_word.lanes;

	assign data_o        = s_q.dq;
	assign data_oe_o     = s_q.dq_oe;
	assign mem_rd_en_o   = s_q.rd_en;
	assign mem_rd_addr_o = s_q.rd_addr;
	assign sleep_o       = s_q.slp_sync[1];

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	a_whole_word : assert property (
		(acc_wr && !whole_word_write_n_i) |-> (wr_word.lanes == sbs_pkg::LANES_ALL))
		else $error("whole-word write missed a lane");
	a_lane_gate : assert property (
		(acc_wr && whole_word_write_n_i)
		|-> (wr_word.lanes == {!lane_high_write_n_i, !lane_low_write_n_i}))
		else $error("lane write mask wrong");
	a_cpu_read : assert property (
		(!sleeping && cpu_new && sel_ok)
		|=> (mem_rd_en_o && mem_rd_addr_o == $past(addr_i) && s_q.mode == sbs_pkg::SBS_RD))
		else $error("processor strobe did not start a read");
	a_cpu_gated : assert property (
		(!sleeping && chip_select_n_i && ctl_addr_strobe_n_i
			&& s_q.mode == sbs_pkg::SBS_DESEL) |=> (s_q.mode == sbs_pkg::SBS_DESEL))
		else $error("processor strobe acted without primary select");
	a_select_two : assert property (
		(!sleeping && new_any && !secondary_select_i) |=> (s_q.mode == sbs_pkg::SBS_DESEL))
		else $error("selected with secondary select low");
	a_select_three : assert property (
		(!sleeping && new_any && third_select_n_i) |=> (s_q.mode == sbs_pkg::SBS_DESEL))
		else $error("selected with third select high");
	a_ctl_write : assert property (
		(!sleeping && ctl_new && sel_ok && wr_c)
		|-> acc_wr && wr_word.addr == addr_i ##1 s_q.mode == sbs_pkg::SBS_WR)
		else $error("controller strobe write not taken");
	a_oe_off : assert property (
		s_q.oe_sync[1] |=> !data_oe_o)
		else $error("data driven while output enable high");
	a_sleep_off : assert property (
		sleeping |=> (!data_oe_o && s_q.mode == sbs_pkg::SBS_SLEEP && !mem_rd_en_o))
		else $error("activity during standby");
	a_step_hold : assert property (
		(cont && burst_step_n_i) |=> (s_q.cnt == $past(s_q.cnt) && $stable(s_q.base)))
		else $error("burst moved on a wait cycle");
	a_step_adv : assert property (
		(cont && step) |=> (s_q.cnt == $past(s_q.cnt) + sbs_pkg::CNT_STEP))
		else $error("burst counter did not advance");
	a_linear_addr : assert property (
		(cont && step && !wr_c && !interleave)
		|=> (mem_rd_addr_o[1:0] == $past(s_q.base[1:0] + s_q.cnt + sbs_pkg::CNT_STEP)))
		else $error("linear burst address wrong");
	a_ilv_addr : assert property (
		(cont && step && !wr_c && interleave)
		|=> (mem_rd_addr_o[1:0] == $past(s_q.base[1:0] ^ (s_q.cnt + sbs_pkg::CNT_STEP))))
		else $error("interleaved burst address wrong");
	a_upper_hold : assert property (
		(cont && !wr_c) |=> (mem_rd_addr_o[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_LSB]
			== $past(s_q.base[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_LSB])))
		else $error("upper address changed in burst");

	// Read data path and driver enable
	a_dq_load : assert property (
		s_q.rd_en |=> (data_o == $past(mem_rd_data_i)))
		else $error("read word not loaded");
	a_oe_on : assert property (
		(s_q.rd_en && !s_q.oe_sync[1] && !sleeping) |=> data_oe_o)
		else $error("read not driven with output enable low");
	a_oe_idle : assert property (
		!s_q.rd_en |=> !data_oe_o)
		else $error("data driven without a read");

	// New access bookkeeping, burst write words and standby exit
	a_cnt_clear : assert property (
		(!sleeping && new_any) |=> (s_q.cnt == sbs_pkg::CNT_RST))
		else $error("burst counter not cleared on new address");
	a_base_load : assert property (
		(!sleeping && new_any) |=> (s_q.base == $past(addr_i)))
		else $error("external address not registered");
	a_cpu_no_wr : assert property (
		(!sleeping && cpu_new) |-> !acc_wr)
		else $error("processor strobe started a write");
	a_ctl_read : assert property (
		(!sleeping && ctl_new && sel_ok && !wr_c)
		|=> (mem_rd_en_o && mem_rd_addr_o == $past(addr_i)))
		else $error("controller strobe read not started");
	a_wr_upper : assert property (
		(cont && acc_wr) |-> (wr_word.addr[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_LSB]
			== s_q.base[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_LSB]))
		else $error("burst write left its upper address");
	a_wr_data : assert property (
		acc_wr |-> (wr_word.data == data_i))
		else $error("write word lanes misplaced");
	a_sleep_exit : assert property (
		(s_q.mode == sbs_pkg::SBS_SLEEP && !sleeping && !new_any)
		|=> (s_q.mode == sbs_pkg::SBS_DESEL))
		else $error("standby exit did not deselect");

	c_cpu_then_write : cover property ((!sleeping && cpu_new && sel_ok) ##1 acc_wr);
	c_ctl_write : cover property (!sleeping && ctl_new && sel_ok && wr_c);
	c_ilv_burst : cover property ((cont && step && interleave) [*3]);
	c_sleep : cover property (sleeping ##1 !sleeping);
	c_lin_wrap : cover property (cont && step && !interleave && s_q.cnt == 2'h3);
endmodule : sbs_ctl
`default_nettype wire

// ===== sbs_fifo.sv
// Write buffer: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module sbs_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	sbs_stream_if.snk   in_s,
	sbs_stream_if.src   out_s
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr_idx;
		logic [AW-1:0]           rd_idx;
		logic [AW:0]             count;
	} sbs_fifo_state_t;

	sbs_fifo_state_t s_q;
	sbs_fifo_state_t s_d;
	logic            push;
	logic            pop;

	assign in_s.ready  = (s_q.count != (AW+1)'(DEPTH));
	assign out_s.valid = (s_q.count != '0);
	assign out_s.data  = s_q.mem[s_q.rd_idx];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr_idx] = in_s.data;
			s_d.wr_idx          = s_q.wr_idx + 1'b1;
		end
		if (pop) begin
			s_d.rd_idx = s_q.rd_idx + 1'b1;
		end
		if (push && !pop) begin
			s_d.count = s_q.count + 1'b1;
		end else if (pop && !push) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_fifo_bound : assert property (@(posedge clk_i) disable iff (rst_i)
		(s_q.count <= (AW+1)'(DEPTH)))
		else $error("fifo count beyond depth");
endmodule : sbs_fifo
`default_nettype wire

// ===== sbs_mem_model.sv
// Far-side array model: sparse word store behind the read port and write drain
`timescale 1ns/1ns
`default_nettype none
module sbs_mem_model (
	input  wire logic        clk_i,
	input  wire logic        stall_i,
	input  wire logic        rd_en_i,
	input  wire logic [18:0] rd_addr_i,
	output logic      [17:0] rd_data_o,
	input  wire logic        wr_valid_i,
	input  wire logic [18:0] wr_addr_i,
	input  wire logic [17:0] wr_data_i,
	input  wire logic [1:0]  wr_lanes_i,
	output logic             wr_ready_o
);
	logic [17:0] mem [logic [18:0]];
	logic [17:0] last_q = 18'h00000;
	logic [17:0] w;
	// Between reads the bus shows the inverse of the last word, never a stale copy
	always @*
		rd_data_o = !rd_en_i ? ~last_q :
			mem.exists(rd_addr_i) ? mem[rd_addr_i] : ~rd_addr_i[17:0];
	always @(posedge clk_i) begin
		if (rd_en_i)
			last_q <= rd_data_o;
		if (wr_valid_i && wr_ready_o) begin
			w = mem.exists(wr_addr_i) ? mem[wr_addr_i] : ~wr_addr_i[17:0];
			if (wr_lanes_i[0])
				w[8:0] = wr_data_i[8:0];
			if (wr_lanes_i[1])
				w[17:9] = wr_data_i[17:9];
			mem[wr_addr_i] = w;
		end
	end
	// Ready moves after the falling edge so the block samples it settled
	initial wr_ready_o = 1'b0;
	always @(negedge clk_i)
		wr_ready_o <= !stall_i;
endmodule : sbs_mem_model
`default_nettype wire

// ===== sbs_pkg.sv
// Shared constants and types for the burst SRAM control block
`default_nettype none
package sbs_pkg;
	localparam int ADDR_W     = 19;
	localparam int DATA_W     = 18;
	localparam int LANE_W     = 9;
	localparam int LANES      = 2;
	localparam int FIFO_DEPTH = 32;
	localparam int LO_LSB     = 0;
	localparam int HI_LSB     = 9;
	localparam int BURST_LSB  = 2;
	localparam logic [1:0] LANES_ALL  = 2'h3;
	localparam logic [1:0] LANES_NONE = 2'h0;
	localparam logic [1:0] CNT_RST    = 2'h0;
	localparam logic [1:0] CNT_STEP   = 2'h1;

	typedef enum logic [1:0] {
		SBS_DESEL = 2'b00,
		SBS_RD    = 2'b01,
		SBS_WR    = 2'b10,
		SBS_SLEEP = 2'b11
	} sbs_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [LANES-1:0]  lanes;
	} sbs_wr_word_t;

	localparam int WR_W = $bits(sbs_wr_word_t);
endpackage : sbs_pkg
`default_nettype wire

// ===== sbs_stream_if.sv
// Valid/ready stream carrier between the control block and its write buffer
`timescale 1ns/1ns
`default_nettype none
interface sbs_stream_if #(
	parameter int W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sbs_stream_if
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the burst SRAM control block and its array model
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk, rst, cs_n, sec, thr_n, cpu_n, ctl_n, step_n, gw_n, bwe_n, lo_n, hi_n;
	logic        oe_n, slp, ord, stall, rd_en, oe, wv, wr_rdy, slp_o, mrdy;
	logic [18:0] addr, rd_a, wa;
	logic [17:0] din, dout, rd_d, wd;
	logic [1:0]  wl;
	logic [17:0] ref_m [logic [18:0]];
	logic [3:0]  wtab [7] = '{4'h7, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE};
	int          num_errors = 0;
	int          samples_checked = 0;
	int          seed = 32'h0E28;
	sbs_ctl dut_u (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr), .data_i(din), .data_o(dout),
		.data_oe_o(oe), .chip_select_n_i(cs_n), .secondary_select_i(sec),
		.third_select_n_i(thr_n), .cpu_addr_strobe_n_i(cpu_n), .ctl_addr_strobe_n_i(ctl_n),
		.burst_step_n_i(step_n), .whole_word_write_n_i(gw_n), .byte_write_gate_n_i(bwe_n),
		.lane_low_write_n_i(lo_n), .lane_high_write_n_i(hi_n), .out_enable_n_i(oe_n),
		.sleep_req_i(slp), .burst_order_i(ord), .mem_rd_en_o(rd_en), .mem_rd_addr_o(rd_a),
		.mem_rd_data_i(rd_d), .mem_wr_valid_o(wv), .mem_wr_addr_o(wa), .mem_wr_data_o(wd),
		.mem_wr_lanes_o(wl), .mem_wr_ready_i(mrdy), .wr_ready_o(wr_rdy), .sleep_o(slp_o));
	sbs_mem_model mem_u (.clk_i(clk), .stall_i(stall), .rd_en_i(rd_en), .rd_addr_i(rd_a),
		.rd_data_o(rd_d), .wr_valid_i(wv), .wr_addr_i(wa), .wr_data_i(wd),
		.wr_lanes_i(wl), .wr_ready_o(mrdy));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	function automatic logic [1:0] lanes(input logic [3:0] c);
		return !c[3] ? 2'h3 : !c[2] ? ~{c[0], c[1]} : 2'h0;
	endfunction : lanes
	function automatic logic [17:0] merge(logic [18:0] a, logic [17:0] d, logic [1:0] l);
		logic [17:0] w;
		w = ref_m.exists(a) ? ref_m[a] : ~a[17:0];
		if (l[0]) w[8:0] = d[8:0];
		if (l[1]) w[17:9] = d[17:9];
		return w;
	endfunction : merge
	function automatic logic [18:0] nxt(logic [18:0] a, logic [1:0] c, logic o);
		return {a[18:2], o ? a[1:0] ^ c : a[1:0] + c};
	endfunction : nxt
	task automatic idle;
		@(negedge clk);
		{cpu_n, ctl_n, step_n, gw_n, bwe_n, lo_n, hi_n, cs_n, sec, thr_n} = 10'h3FA;
	endtask : idle
	// All strobe and write controls change together so no pin is driven twice in a step
	task automatic strobe(logic [18:0] a, logic cpu, logic [2:0] sel, logic [3:0] wc);
		@(negedge clk);
		addr = a;
		{cpu_n, ctl_n, step_n, gw_n, bwe_n, lo_n, hi_n, cs_n, sec, thr_n} = {~cpu, cpu, 1'b1, wc, sel};
	endtask : strobe
	task automatic wr(logic [18:0] a, logic [17:0] d, logic [3:0] wc);
		strobe(a, 1'b0, 3'h2, wc);
		din = d;
		if (wr_rdy === 1'b1)
			ref_m[a] = merge(a, d, lanes(wc));
	endtask : wr
	task automatic drain;
		int k;
		idle();
		stall = 1'b0;
		repeat (2) @(posedge clk);
		for (k = 0; k < 300 && wv !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		if (wv !== 1'b0) begin
			num_errors++;
			report_and_stop();
		end
	endtask : drain
	// Reads do not see buffered writes, so the buffer is emptied first
	task automatic rd(logic [18:0] a, logic exp_oe);
		drain();
		strobe(a, 1'b1, 3'h2, 4'hF);
		idle();
		@(posedge clk);
		#1;
		chk("rd_en", rd_en, 1);
		chk("rd_addr", rd_a, a);
		@(posedge clk);
		#1;
		chk("rd_data", dout, ref_m[a]);
		chk("data_oe", oe, exp_oe);
	endtask : rd
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
	initial begin
		logic [18:0] a, a0;
		logic [1:0]  c;
		int          i, k;
		{rst, cpu_n, ctl_n, step_n, gw_n, bwe_n, lo_n, hi_n, cs_n, sec, thr_n} = 11'h7FA;
		{oe_n, slp, ord, stall, addr, din} = '0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("wr_ready", wr_rdy, 1);
		chk("sleep", slp_o, 0);
		for (i = 0; i < 7; i++) begin
			a = 19'($random(seed));
			wr(a, 18'($random(seed)), 4'h7);
			wr(a, 18'($random(seed)), wtab[i]);
			rd(a, 1'b1);
		end
		strobe(a, 1'b1, 3'h2, 4'hF);
		@(negedge clk);
		{cpu_n, gw_n} = 2'h2;
		din = 18'h2A5A5;
		ref_m[a] = merge(a, din, 2'h3);
		rd(a, 1'b1);
		a0 = a;
		$display("Test writes done");
		for (i = 0; i < 8; i++) begin
			@(negedge clk);
			ord = i[2];
			repeat (4) @(posedge clk);
			a = 19'($random(seed));
			a[1:0] = i[1:0];
			strobe(a, 1'b1, 3'h2, 4'hF);
			c = 2'h0;
			for (k = 0; k < 5; k++) begin
				@(negedge clk);
				{cpu_n, step_n} = {1'b1, k == 1};
				@(posedge clk);
				#1;
				// The access on a stepping edge already uses the advanced count
				c = c + {1'b0, !step_n};
				chk("burst", rd_a, nxt(a, c, ord));
			end
		end
		$display("Test bursts done");
		for (i = 0; i < 3; i++) begin
			if (i < 2)
				strobe(a0, 1'b1, 3'h2, 4'hF);
			strobe(a0, i == 2, i == 0 ? 3'h0 : i == 1 ? 3'h3 : 3'h6, 4'hF);
			repeat (2) begin
				idle();
				@(posedge clk);
				#1;
				chk("desel", rd_en, 0);
			end
		end
		@(negedge clk);
		oe_n = 1'b1;
		repeat (4) @(posedge clk);
		rd(a0, 1'b0);
		@(negedge clk);
		oe_n = 1'b0;
		slp = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("sleep", slp_o, 1);
		strobe(a0, 1'b1, 3'h2, 4'hF);
		idle();
		repeat (2) @(posedge clk);
		#1;
		chk("sleep_rd", rd_en, 0);
		@(negedge clk);
		slp = 1'b0;
		rd(a0, 1'b1);
		$display("Test select, enable and sleep done");
		@(negedge clk);
		stall = 1'b1;
		for (i = 0; i < 33; i++)
			wr(i == 32 ? a0 : a0 + 19'(i + 1), 18'(i), 4'h7);
		chk("full", wr_rdy, 0);
		rd(a0, 1'b1);
		rd(a0 + 19'h20, 1'b1);
		for (i = 0; i < 40; i++) begin
			a = {a0[18:3], 3'($random(seed))};
			@(negedge clk);
			stall = 1'($random(seed));
			if (!ref_m.exists(a) || $random(seed) % 2)
				wr(a, 18'($random(seed)), wtab[i % 7]);
			else
				rd(a, 1'b1);
		end
		$display("Test buffer and random done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
